// >>> hdl/esag_guard.sv
// Notes on behaviour
// RQ1: power-up copies nonvolatile words into shadow.
// RQ2: shadow same layout, address plus 0x40.
// RQ3: no ECC in shadow; unused bits read zero.
// RQ4: shadow shares protection; reads always allowed.
// RQ5: five key bytes at 0x3C unlock.
// RQ6: controller unlocks once per power-on.
// RQ7: lock 0xC blocks nonvolatile, shadow still writable.
// RQ8: lock 0x3 blocks nonvolatile and shadow writes.
// RQ9: exception fields default to zero.
// RQ10: word 0x17 keyless with unlock waiver.
// RQ11: word 0x1F keyless needs both waivers.
// RQ12: under lock, user words need lock bypass.
// RQ13: address, data, then trigger bit.
// RQ14: controller loads all four data bytes first.
// RQ15: trigger moves 32-bit data to target.
// RQ16: write-done set; nonvolatile takes to 24 ms.
// RQ17: shadow write completes in one cycle.
// RQ18: refused write ends, sets done and warning.
// RQ19: wrong key byte restarts the sequence.
// RQ20: reset clears unlock and sequence tracker.
`default_nettype none
module esag_guard
    import esag_pkg::*;
#(
    parameter int unsigned NVM_TIMEOUT = NVM_TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic regWe,
    input wire logic regRe,
    input wire logic [5:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic nvmReq,
    output logic nvmWe,
    output logic [esag_pkg::IDX_W-1:0] nvmAddr,
    output logic [31:0] nvmWdata,
    input wire logic [31:0] nvmRdata,
    input wire logic nvmDone,
    input wire logic nvmErr,
    input wire logic [esag_pkg::IDX_W-1:0] cfgIdx,
    output logic [esag_pkg::DATA_W-1:0] cfgData,
    output logic bootDone
);
    // Everything below that ends in _q is cleared by the power-on reset alone.
    logic keyUnlocked; // Key sequence completed since reset.
    esag_state_t state_q, state_d; // Sequencer state.
    logic [DATA_W-1:0] shadow_q [NVM_WORDS], shadow_d [NVM_WORDS]; // Volatile copies.
    logic [6:0] cfg_q, cfg_d; // Protection fields as stored at power-up.
    logic [IDX_W-1:0] idx_q, idx_d; // Word index for boot copy and writes.
    logic [7:0] ewa_q, ewa_d; // Extended write address.
    logic [31:0] ewd_q, ewd_d; // Extended write data.
    logic wdn_q, wdn_d; // Write done.
    logic xee_q, xee_d; // Extended access warning.
    logic req_q, req_d; // Request to the nonvolatile macro.
    logic we_q, we_d; // Request is a write.
    logic [TMO_W-1:0] tmo_q, tmo_d; // Nonvolatile write watchdog.
    logic [7:0] rdata_q, rdata_d; // Registered read data.
    logic [DATA_W-1:0] cfgData_q; // Registered shadow read.
    logic [DATA_W-1:0] cfgData_d; // Shadow word picked for the operating logic.
    // Decode of the pending write; all of it settles within the cycle.
    logic trigger; // Software wrote the trigger bit.
    logic inShadow; // Target lies in the shadow window.
    logic inNvm; // Target lies in the nonvolatile window.
    logic [IDX_W-1:0] tgtIdx; // Word index of the target.
    logic permitted; // Target may be written now.

    // The unlock tracker watches only the key port.
    // The waivers never feed it, so it always reports the key state alone.
    esag_key_tracker u_key (
        .ref_clk(ref_clk),
        .rst(rst),
        .keyWe(regWe && regAddr == REG_KEY),
        .keyByte(regWdata),
        .unlocked(keyUnlocked)
    );

    // Access class of one word; shadow ignores the nonvolatile-only lock.
    function automatic esag_acc_t accessOf(input logic [IDX_W-1:0] idx, input logic shadow,
                                           input logic [6:0] cfg);
        logic locked;
        logic cud;
        logic del;
        logic dur;
        // Lock 0x3 closes both windows, lock 0xC only the nonvolatile one.
        locked = (cfg[LOCK_LSB +: 4] == LOCK_ALL) || (!shadow && cfg[LOCK_LSB +: 4] == LOCK_NVM); // RQ7 RQ8
        cud = cfg[CUD_BIT];
        del = cfg[DEL_BIT];
        dur = cfg[DUR_BIT];
        // Any location needs the key unless a lock or a waiver below says otherwise.
        accessOf = ACC_KEY;
        if (!locked) begin
            // Without a lock only the unlock waiver can drop the key requirement.
            if (idx == USER2_IDX && dur) begin
                accessOf = ACC_ALWAYS; // RQ10
            end else if (idx == USER1_IDX && dur && cud) begin
                accessOf = ACC_ALWAYS; // RQ11
            end
        end else if (del && (idx == USER2_IDX || (idx == USER1_IDX && cud))) begin
            // Under a lock the bypass keeps the user words open and nothing else.
            accessOf = dur ? ACC_ALWAYS : ACC_KEY; // RQ12
        end else begin
            accessOf = ACC_NEVER; // RQ12
        end
    endfunction

    // Decode the target of the pending extended write.
    always_comb begin
        inNvm = ewa_q < 8'(NVM_WORDS);
        inShadow = (ewa_q >= SHADOW_OFS) && (ewa_q < SHADOW_OFS + 8'(NVM_WORDS)); // RQ2
        tgtIdx = ewa_q[IDX_W-1:0];
        // Outside both windows nothing is writable, whatever the class says.
        case (accessOf(tgtIdx, inShadow, cfg_q))
            ACC_ALWAYS: permitted = inNvm || inShadow;
            ACC_KEY: permitted = (inNvm || inShadow) && keyUnlocked; // RQ4
            default: permitted = 1'b0;
        endcase
        // Only bit 7 starts a transfer; a clear-only write leaves the sequencer alone.
        trigger = regWe && regAddr == REG_EWCS && regWdata[EWCS_TRIG_BIT]; // RQ13
    end

    // Direct register writes: target address and the four data bytes.
    always_comb begin
        ewa_d = ewa_q;
        ewd_d = ewd_q;
        if (regWe) begin
            // Data bytes land with the high byte at REG_EWD0, one frame each, in any order.
            case (regAddr)
                REG_EWA: ewa_d = regWdata; // RQ13
                REG_EWD0: ewd_d[31:24] = regWdata; // RQ14
                REG_EWD1: ewd_d[23:16] = regWdata; // RQ14
                REG_EWD2: ewd_d[15:8] = regWdata; // RQ14
                REG_EWD3: ewd_d[7:0] = regWdata; // RQ14
                default: ;
            endcase
        end
    end

    // Sequencer: boot copy, then write transactions. A trigger while busy is ignored, since
    // the macro cannot take a second request and the data could already be half consumed.
    always_comb begin
        state_d = state_q;
        shadow_d = shadow_q;
        cfg_d = cfg_q;
        idx_d = idx_q;
        req_d = req_q;
        we_d = we_q;
        tmo_d = tmo_q;
        wdn_d = wdn_q;
        xee_d = xee_q;
        // Software clears the warning; any new warning below overrides the clear.
        if (regWe && regAddr == REG_EWCS && regWdata[EWCS_XCLR_BIT]) begin
            xee_d = 1'b0;
        end
        unique case (state_q)
            ST_BOOT_REQ: begin
                // Ask for the next word; the copy only ever reads.
                req_d = 1'b1; // RQ1
                we_d = 1'b0;
                state_d = ST_BOOT_WAIT;
            end
            ST_BOOT_WAIT: begin
                if (nvmDone) begin
                    req_d = 1'b0;
                    // The top byte holds check bits and never reaches the shadow copy.
                    shadow_d[idx_q] = nvmRdata[DATA_W-1:0]; // RQ1 RQ3
                    // The protection word is latched here and nowhere else.
                    if (idx_q == CFG_IDX) begin
                        cfg_d = nvmRdata[6:0]; // RQ7 RQ8
                    end
                    // After the last word the block starts taking triggers.
                    if (idx_q == LAST_IDX) begin
                        idx_d = '0;
                        state_d = ST_IDLE;
                    end else begin
                        // The request drops for one cycle between two words.
                        idx_d = idx_q + 5'h01;
                        state_d = ST_BOOT_REQ;
                    end
                end
            end
            ST_IDLE: begin
                if (trigger) begin
                    // The done flag drops at a nonvolatile trigger and rises when that transfer ends; refused and shadow writes set it at once.
                    wdn_d = 1'b0;
                    if (!permitted) begin
                        // Refused: nothing is stored and both flags report it.
                        wdn_d = 1'b1; // RQ18
                        xee_d = 1'b1; // RQ18
                    end else if (inShadow) begin
                        // Shadow writes finish in the trigger's own cycle.
                        shadow_d[tgtIdx] = ewd_q[DATA_W-1:0]; // RQ15 RQ17
                        wdn_d = 1'b1; // RQ16 RQ17
                    end else begin
                        // Nonvolatile writes go to the macro, which may take up to 24 ms.
                        idx_d = tgtIdx; // RQ15
                        req_d = 1'b1;
                        we_d = 1'b1;
                        tmo_d = '0;
                        state_d = ST_NVM_WAIT;
                    end
                end
            end
            ST_NVM_WAIT: begin
                // The watchdog ends a write that the macro never answers.
                tmo_d = tmo_q + 20'h00001;
                if (nvmDone || tmo_q == TMO_W'(NVM_TIMEOUT)) begin
                    req_d = 1'b0;
                    we_d = 1'b0;
                    wdn_d = 1'b1; // RQ16
                    // A macro error and an abort both count as a failed write.
                    if (nvmErr || !nvmDone) begin
                        xee_d = 1'b1; // An aborted write also warns.
                    end
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // Read path: address, data and status registers readable at any time, no unlock needed.
    always_comb begin
        rdata_d = 8'h00;
        cfgData_d = shadow_q[cfgIdx]; // RQ1
        // Idle cycles, holes and the write-only key port all read as zero.
        if (regRe) begin
            case (regAddr)
                REG_EWA: rdata_d = ewa_q; // RQ4
                REG_EWD0: rdata_d = ewd_q[31:24];
                REG_EWD1: rdata_d = ewd_q[23:16];
                REG_EWD2: rdata_d = ewd_q[15:8];
                REG_EWD3: rdata_d = ewd_q[7:0];
                // Busy also covers the power-up copy.
                REG_EWST: rdata_d = {5'h00, state_q != ST_IDLE, xee_q, wdn_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Sequencer storage. Exception fields stay zero until the boot copy, so no waiver
    // can open a location before the real protection word has been read.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_BOOT_REQ;
            for (int i = 0; i < NVM_WORDS; i++) begin
                shadow_q[i] <= '0;
            end
            cfg_q <= CFG_RESET; // RQ9
            idx_q <= '0;
            wdn_q <= 1'b0;
            xee_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            tmo_q <= '0;
        end else begin
            state_q <= state_d;
            shadow_q <= shadow_d;
            cfg_q <= cfg_d;
            idx_q <= idx_d;
            wdn_q <= wdn_d;
            xee_q <= xee_d;
            req_q <= req_d;
            we_q <= we_d;
            tmo_q <= tmo_d;
        end
    end

    // Write set-up registers. They survive a refused write, so software can send the key
    // and trigger again without loading the data once more.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ewa_q <= 8'h00;
            ewd_q <= 32'h00000000;
        end else begin
            ewa_q <= ewa_d;
            ewd_q <= ewd_d;
        end
    end

    // Read data registers. Both reads cost one cycle, which keeps the outputs free of
    // glitches from the address decode.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
            cfgData_q <= '0;
        end else begin
            rdata_q <= rdata_d;
            cfgData_q <= cfgData_d; // RQ1
        end
    end

    // Outputs to the macro and to the operating logic.
    assign regRdata = rdata_q;
    assign nvmReq = req_q;
    assign nvmWe = we_q;
    assign nvmAddr = idx_q;
    // The macro takes the whole word; the next boot copy keeps only its low 24 bits.
    assign nvmWdata = ewd_q;
    assign cfgData = cfgData_q;
    // Operating logic may trust the shadow once the copy is over.
    assign bootDone = (state_q == ST_IDLE) || (state_q == ST_NVM_WAIT);
endmodule
`default_nettype wire

// >>> hdl/esag_pkg.sv
`default_nettype none
package esag_pkg;
    // Direct register byte addresses seen by the serial front end.
    localparam logic [5:0] REG_EWA = 6'h02;
    localparam logic [5:0] REG_EWD0 = 6'h04;
    localparam logic [5:0] REG_EWD1 = 6'h05;
    localparam logic [5:0] REG_EWD2 = 6'h06;
    localparam logic [5:0] REG_EWD3 = 6'h07;
    localparam logic [5:0] REG_EWCS = 6'h08;
    localparam logic [5:0] REG_EWST = 6'h09;
    localparam logic [5:0] REG_KEY = 6'h3C;
    // Control and status bit positions.
    localparam int EWCS_TRIG_BIT = 7;
    localparam int EWCS_XCLR_BIT = 1;
    localparam int ST_WDN_BIT = 0;
    localparam int ST_XEE_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    // Extended address map.
    localparam logic [7:0] SHADOW_OFS = 8'h40;
    localparam int IDX_W = 5;
    localparam int NVM_WORDS = 32;
    localparam int DATA_W = 24;
    localparam logic [4:0] USER2_IDX = 5'h17;
    localparam logic [4:0] USER1_IDX = 5'h1F;
    localparam logic [4:0] CFG_IDX = 5'h18;
    localparam logic [4:0] LAST_IDX = 5'h1F;
    // Protection fields inside the configuration word.
    localparam int LOCK_LSB = 0;
    localparam int CUD_BIT = 4;
    localparam int DEL_BIT = 5;
    localparam int DUR_BIT = 6;
    localparam logic [3:0] LOCK_NVM = 4'hC;
    localparam logic [3:0] LOCK_ALL = 4'h3;
    localparam logic [6:0] CFG_RESET = 7'h00;
    // Unlock key bytes in the order they must arrive.
    localparam logic [7:0] KEY0 = 8'h00;
    localparam logic [7:0] KEY1 = 8'h27;
    localparam logic [7:0] KEY2 = 8'h81;
    localparam logic [7:0] KEY3 = 8'h1F;
    localparam logic [7:0] KEY4 = 8'h77;
    localparam logic [2:0] KEY_LAST = 3'h4;
    // Longest nonvolatile write time and its cycle count.
    localparam int NVM_WRITE_MS = 24;
    localparam int CLK_HZ = 25000000;
    localparam int NVM_TIMEOUT_CYC = NVM_WRITE_MS * (CLK_HZ / 1000);
    localparam int TMO_W = 20;
    // Sequencer states, Gray along boot, idle, write.
    typedef enum logic [1:0] {
        ST_BOOT_REQ = 2'h0,
        ST_BOOT_WAIT = 2'h1,
        ST_IDLE = 2'h3,
        ST_NVM_WAIT = 2'h2
    } esag_state_t;
    // Write permission class of a location.
    typedef enum logic [1:0] {
        ACC_NEVER = 2'h0,
        ACC_KEY = 2'h1,
        ACC_ALWAYS = 2'h2
    } esag_acc_t;
endpackage
`default_nettype wire

// >>> hdl/esag_key_tracker.sv
`default_nettype none
module esag_key_tracker
    import esag_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic keyWe,
    input wire logic [7:0] keyByte,
    output logic unlocked
);
    logic [2:0] step_q, step_d; // Next key byte expected.
    logic unlock_q, unlock_d; // Write access opened.

    // Key byte expected at a given step.
    function automatic logic [7:0] keyAt(input logic [2:0] s);
        case (s)
            3'h0: keyAt = KEY0;
            3'h1: keyAt = KEY1;
            3'h2: keyAt = KEY2;
            3'h3: keyAt = KEY3;
            default: keyAt = KEY4;
        endcase
    endfunction

    // Advance on a match; a wrong byte restarts, but is checked as a first byte so it is not wasted.
    always_comb begin
        step_d = step_q;
        unlock_d = unlock_q;
        if (keyWe && !unlock_q) begin
            if (keyByte == keyAt(step_q)) begin
                if (step_q == KEY_LAST) begin
                    unlock_d = 1'b1; // RQ5
                    step_d = 3'h0;
                end else begin
                    step_d = step_q + 3'h1; // RQ5
                end
            end else if (keyByte == KEY0) begin
                step_d = 3'h1; // RQ19
            end else begin
                step_d = 3'h0; // RQ19
            end
        end
    end

    // Power-on reset closes access and rewinds the sequence.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            step_q <= 3'h0; // RQ20
            unlock_q <= 1'b0; // RQ20
        end else begin
            step_q <= step_d;
            unlock_q <= unlock_d;
        end
    end

    assign unlocked = unlock_q;
endmodule
`default_nettype wire

// >>> verif/esag_nvm_model.sv
`default_nettype none
module esag_nvm_model
    import esag_pkg::*;
#(
    parameter int DELAY = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic fail,
    input wire logic nvmReq,
    input wire logic nvmWe,
    input wire logic [esag_pkg::IDX_W-1:0] nvmAddr,
    input wire logic [31:0] nvmWdata,
    output logic [31:0] nvmRdata,
    output logic nvmDone,
    output logic nvmErr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Stored words; the bench rewrites the protection word during each reset.
    logic [31:0] mem [NVM_WORDS];
    logic [31:0] word_q = 32'h0;
    int cnt;
    initial for (int i = 0; i < NVM_WORDS; i++) mem[i] = 32'hB7000000 ^ (i * 32'h00050301);
    // One request at a time after a fixed wait; a stall withholds the answer so timeouts can be seen.
    always @(posedge ref_clk or posedge rst) begin
        nvmDone <= 1'b0;
        if (rst || !nvmReq || stall) begin
            cnt <= 0;
        end else if (!nvmDone && cnt < DELAY) begin
            cnt <= cnt + 1;
        end else if (!nvmDone) begin
            cnt <= 0;
            nvmDone <= 1'b1;
            word_q <= mem[nvmAddr];
            if (nvmWe) mem[nvmAddr] <= nvmWdata;
        end
    end
    // Outside the done pulse the bus shows the inverse, so stale data never passes for an answer.
    assign nvmRdata = nvmDone ? word_q : ~word_q;
    // A failing write still answers, but flags the error with its done pulse.
    assign nvmErr = fail && nvmDone;
endmodule
`default_nettype wire

// >>> verif/esag_guard_properties.sv
`default_nettype none
module esag_guard_properties
    import esag_pkg::*;
#(
    parameter int unsigned NVM_TIMEOUT = NVM_TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic regWe,
    input wire logic [5:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic nvmReq,
    input wire logic nvmWe,
    input wire logic [esag_pkg::IDX_W-1:0] nvmAddr,
    input wire logic [31:0] nvmWdata,
    input wire logic [31:0] nvmRdata,
    input wire logic nvmDone,
    input wire logic bootDone
);
    logic [6:0] cfg_q; // Protection word seen during the power-up copy.
    logic [7:0] ewa_q; // Target address as last written.
    logic [31:0] ewd_q; // Data bytes, shifted in high byte first.
    logic trig;
    logic locked;
    assign trig = regWe && regAddr == REG_EWCS && regWdata[EWCS_TRIG_BIT];
    assign locked = cfg_q[3:0] == LOCK_NVM || cfg_q[3:0] == LOCK_ALL;
    // The protection word is caught from the boot read, as the design takes it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= CFG_RESET;
        end else if (nvmDone && !bootDone && nvmAddr == CFG_IDX) begin
            cfg_q <= nvmRdata[6:0];
        end
    end
    // Mirror of the write set-up; relies on data bytes arriving in address order.
    always_ff @(posedge ref_clk) begin
        if (regWe && regAddr == REG_EWA) begin
            ewa_q <= regWdata;
        end
        if (regWe && regAddr >= REG_EWD0 && regAddr <= REG_EWD3) begin
            ewd_q <= {ewd_q[23:0], regWdata};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_boot_reads; !bootDone && nvmReq |-> !nvmWe; endproperty
    a_boot_reads: assert property (p_boot_reads) else $error("write during power-up copy");
    property p_boot_end; $rose(bootDone) |-> $past(nvmDone) && $past(nvmAddr) == LAST_IDX; endproperty
    a_boot_end: assert property (p_boot_end) else $error("copy ended before last word");
    property p_release; bootDone && nvmReq && nvmDone |=> !nvmReq; endproperty
    a_release: assert property (p_release) else $error("request held after done");
    property p_hold; nvmReq && !nvmDone |=> !nvmReq || ($stable(nvmAddr) && $stable(nvmWdata)); endproperty
    a_hold: assert property (p_hold) else $error("request changed while waiting");
    property p_trig; $rose(nvmReq) && bootDone |-> $past(trig); endproperty
    a_trig: assert property (p_trig) else $error("request without trigger");
    property p_wr_data; $rose(nvmReq) && nvmWe |-> nvmWdata == ewd_q && nvmAddr == ewa_q[4:0] && ewa_q < 8'h20;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("wrong write data or target");
    property p_lock_user; $rose(nvmReq) && nvmWe && locked |-> cfg_q[DEL_BIT] &&
        (nvmAddr == USER2_IDX || (nvmAddr == USER1_IDX && cfg_q[CUD_BIT])); endproperty
    a_lock_user: assert property (p_lock_user) else $error("locked write let through");
    property p_lock_c; $rose(nvmReq) && nvmWe && cfg_q[3:0] == LOCK_NVM |-> nvmAddr == USER2_IDX ||
        nvmAddr == USER1_IDX; endproperty
    a_lock_c: assert property (p_lock_c) else $error("write under permanent lock");
    cover property ($rose(bootDone));
    cover property (bootDone && nvmReq && nvmDone);
    cover property ($rose(nvmReq) && nvmWe && locked);
endmodule
bind esag_guard esag_guard_properties #(.NVM_TIMEOUT(NVM_TIMEOUT)) u_props (.ref_clk(ref_clk), .rst(rst),
    .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata), .nvmReq(nvmReq), .nvmWe(nvmWe),
    .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmRdata(nvmRdata), .nvmDone(nvmDone), .bootDone(bootDone));
`default_nettype wire

// >>> verif/tb.sv
`default_nettype none
module tb
    import esag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] D1 = 32'hC3A55A3C;
    localparam logic [31:0] D2 = 32'h00A45678;
    localparam logic [39:0] KEYS = {KEY0, KEY1, KEY2, KEY3, KEY4};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic regWe = 1'b0;
    logic regRe = 1'b0;
    logic stall = 1'b0;
    logic fail = 1'b0;
    logic [5:0] regAddr = 6'h00;
    logic [7:0] regWdata = 8'h00;
    logic [IDX_W-1:0] cfgIdx = 5'h00;
    logic [7:0] regRdata, junk;
    logic nvmReq, nvmWe, nvmDone, nvmErr, bootDone;
    logic [IDX_W-1:0] nvmAddr;
    logic [31:0] nvmWdata, nvmRdata;
    logic [DATA_W-1:0] cfgData;
    int mismatches = 0;
    int samplesChecked = 0;
    always #20 ref_clk = ~ref_clk;
    // A short timeout keeps the abort case quick.
    esag_guard #(.NVM_TIMEOUT(50)) DUT (.ref_clk(ref_clk), .rst(rst), .regWe(regWe), .regRe(regRe),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .nvmReq(nvmReq), .nvmWe(nvmWe),
        .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmRdata(nvmRdata), .nvmDone(nvmDone),
        .nvmErr(nvmErr), .cfgIdx(cfgIdx), .cfgData(cfgData), .bootDone(bootDone));
    esag_nvm_model u_nvm (.ref_clk(ref_clk), .rst(rst), .stall(stall), .fail(fail), .nvmReq(nvmReq), .nvmWe(nvmWe),
        .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmRdata(nvmRdata), .nvmDone(nvmDone), .nvmErr(nvmErr));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samplesChecked++;
        if (seen !== want) begin
            mismatches++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One register byte access; the idle cycle after it keeps strobes from being set twice at once.
    task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        regWe = we;
        regRe = !we;
        regAddr = a;
        regWdata = d;
        @(posedge ref_clk);
        #1 regWe = 1'b0;
        regRe = 1'b0;
        q = regRdata;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic keys(input logic [39:0] seq);
        for (int i = 4; i >= 0; i--) bus(1'b1, REG_KEY, seq[8 * i +: 8], junk);
    endtask
    // Warning clear, target, data high byte first, trigger, then a bounded poll of the done flag.
    task automatic xw(input logic [7:0] ea, input logic [31:0] d, input logic [7:0] want);
        logic [7:0] s;
        int n;
        n = 0;
        bus(1'b1, REG_EWCS, 8'h02, s);
        bus(1'b1, REG_EWA, ea, s);
        for (int b = 0; b < 4; b++) bus(1'b1, REG_EWD0 + 6'(b), d[31 - 8 * b -: 8], s);
        bus(1'b1, REG_EWCS, 8'h80, s);
        s = 8'h00;
        while (s[0] !== 1'b1 && n < 100) begin
            bus(1'b0, REG_EWST, 8'h00, s);
            n++;
        end
        chk({24'h0, s}, {24'h0, want});
        if (ea[6]) chk(n, 1);
    endtask
    task automatic sh(input logic [4:0] i, input logic [23:0] want);
        cfgIdx = i;
        @(posedge ref_clk);
        #1 chk({8'h00, cfgData}, {8'h00, want});
    endtask
    // The protection word is planted while reset holds, before the copy starts.
    task automatic power(input logic [31:0] cfg);
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        u_nvm.mem[CFG_IDX] = cfg;
        #1 rst = 1'b0;
        for (int i = 0; i < 600 && bootDone !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk({31'h0, bootDone}, 32'h1);
    endtask
    task automatic t_boot();
        power(32'h0);
        for (int i = 0; i < NVM_WORDS; i++) sh(5'(i), u_nvm.mem[i][23:0]);
    endtask
    // Key trouble: a wrong byte mid-sequence must cost the whole sequence.
    task automatic t_key();
        xw(8'h43, D1, 8'h03);
        sh(5'h03, u_nvm.mem[3][23:0]);
        xw(8'h57, D1, 8'h03);
        keys({KEY0, KEY1, KEY2, 8'h33, KEY3});
        bus(1'b1, REG_KEY, KEY4, junk);
        xw(8'h43, D1, 8'h03);
        keys(KEYS);
        xw(8'h43, D1, 8'h01);
        sh(5'h03, D1[23:0]);
    endtask
    task automatic t_nvm();
        logic [23:0] old;
        old = u_nvm.mem[5][23:0];
        xw(8'h05, D2, 8'h01);
        chk(u_nvm.mem[5], D2);
        sh(5'h05, old);
        stall = 1'b1;
        xw(8'h06, D2, 8'h03);
        stall = 1'b0;
        fail = 1'b1;
        xw(8'h07, D2, 8'h03);
        fail = 1'b0;
    endtask
    task automatic t_lock_c();
        power(32'h7C);
        xw(8'h41, D1, 8'h03);
        xw(8'h57, D1, 8'h01);
        xw(8'h5F, D1, 8'h01);
        xw(8'h1F, D2, 8'h01);
        chk(u_nvm.mem[31], D2);
        keys(KEYS);
        xw(8'h41, D1, 8'h01);
        xw(8'h01, D2, 8'h03);
    endtask
    task automatic t_lock_all();
        power(32'h33);
        xw(8'h57, D1, 8'h03);
        keys(KEYS);
        xw(8'h57, D1, 8'h01);
        xw(8'h1F, D1, 8'h01);
        xw(8'h41, D1, 8'h03);
        xw(8'h01, D2, 8'h03);
        bus(1'b0, REG_EWA, 8'h00, junk);
        chk({24'h0, junk}, 32'h00000001);
        bus(1'b0, REG_EWD3, 8'h00, junk);
        chk({24'h0, junk}, {24'h0, D2[7:0]});
        sh(5'h01, u_nvm.mem[1][23:0]);
    endtask
    initial begin
        t_boot();
        t_key();
        t_nvm();
        t_lock_c();
        t_lock_all();
        conclude();
    end
    // The whole sequence needs about a thousand cycles; ten thousand means a hang.
    initial begin
        #400000;
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire
